// File: rtl/ctsu_top.sv
// Purpose: Two capture units sharing the first and third timers.
// Assumes: Timer counts arrive on clk_sys_in; capture pins are async.
// Notes: Compare and PWM waveform logic live outside this block.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module ctsu_top (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Register port
  input wire ctsu_pkg::ctsu_bus_req_t bus_in,
  output logic [ctsu_pkg::DATA_W-1:0] rdata_out,
  // Timers
  input wire ctsu_pkg::ctsu_timers_t timers_in,
  input wire logic [ctsu_pkg::NUM_UNITS-1:0] cmp_match_in,
  output logic first_timer_reset_out,
  output logic third_timer_reset_out,
  output ctsu_pkg::ctsu_tb_t [ctsu_pkg::NUM_UNITS-1:0] time_base_out,
  // Capture pins
  input wire logic first_unit_pin_in,
  input wire logic default_route_pin_in,
  input wire logic alternate_route_pin_in,
  // Status
  output logic [ctsu_pkg::NUM_UNITS-1:0] unit_irq_flag_out,
  output logic [ctsu_pkg::NUM_UNITS-1:0] unit_irq_enable_out,
  output logic second_unit_pin_route_cfg_out
);

  localparam int NU = ctsu_pkg::NUM_UNITS;
  localparam int DW = ctsu_pkg::DATA_W;

  // Pin synchronisation.
  logic [2:0] pins_sync;
  logic [NU-1:0] unit_pin;

  ctsu_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .async_in({alternate_route_pin_in, default_route_pin_in, first_unit_pin_in}),
    .sync_out(pins_sync)
  );

  // Shared registers.
  logic [DW-1:0] t3ctl_r;
  logic [NU-1:0] ien_r;
  logic route_r;
  logic [DW-1:0] rdata_r;
  logic first_rst_r;
  logic third_rst_r;

  // The level watched is the pad itself, so a port write to an output
  // pin is seen exactly like an external edge.
  assign unit_pin[0] = pins_sync[0];
  assign unit_pin[1] = route_r ? pins_sync[1] : pins_sync[2];

  // Decode of the shared registers.
  wire wr_t3ctl = bus_in.wr && (bus_in.addr == ctsu_pkg::OFS_T3CTL);
  wire wr_flags = bus_in.wr && (bus_in.addr == ctsu_pkg::OFS_FLAGS);
  wire wr_ien = bus_in.wr && (bus_in.addr == ctsu_pkg::OFS_IEN);
  wire wr_route = bus_in.wr && (bus_in.addr == ctsu_pkg::OFS_ROUTE);

  // Per-unit views gathered for the read mux and the timer reset.
  logic [NU-1:0][DW-1:0] ctrl_v;
  logic [NU-1:0][DW-1:0] low_v;
  logic [NU-1:0][DW-1:0] high_v;
  logic [NU-1:0] flag_v;
  logic [NU-1:0] rd_hit_v;
  logic [NU-1:0][DW-1:0] rd_data_v;
  logic [NU-1:0] special_v;
  logic [NU-1:0] sel_third_v;
  logic [NU-1:0] hit_first_v;
  logic [NU-1:0] hit_third_v;

  assign sel_third_v[0] = t3ctl_r[ctsu_pkg::T3_SEL_U0_BIT];
  assign sel_third_v[1] = t3ctl_r[ctsu_pkg::T3_SEL_U1_BIT];

  genvar u;
  generate
    for (u = 0; u < NU; u++) begin : g_unit
      localparam logic [ctsu_pkg::ADDR_W-1:0] BASE =
        ctsu_pkg::ADDR_W'(u * ctsu_pkg::UNIT_STRIDE);
      logic [DW-1:0] ctrl_r;
      logic [DW-1:0] low_r;
      logic [DW-1:0] low_nxt;
      logic [DW-1:0] high_r;
      logic [DW-1:0] high_nxt;
      logic flag_r;
      logic flag_nxt;
      logic cap;
      ctsu_pkg::ctsu_tb_t tb;
      logic [ctsu_pkg::TMR_W-1:0] tmr_val;
      wire [ctsu_pkg::MODE_W-1:0] mode = ctrl_r[ctsu_pkg::MODE_W-1:0];
      wire is_pwm = (mode[3:2] == ctsu_pkg::CLASS_PWM);
      wire a_ctrl = (bus_in.addr == BASE + ctsu_pkg::OFS_CTRL);
      wire a_low = (bus_in.addr == BASE + ctsu_pkg::OFS_LOW);
      wire a_high = (bus_in.addr == BASE + ctsu_pkg::OFS_HIGH);
      wire wr_ctrl = bus_in.wr && a_ctrl;
      wire wr_low = bus_in.wr && a_low;
      wire wr_high = bus_in.wr && a_high;

      ctsu_cap_unit u_cap (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .mode_in(mode),
        .pin_in(unit_pin[u]),
        .cap_out(cap)
      );

      // PWM always runs off the second timer; every other active mode
      // takes the first or third timer, chosen per unit.
      assign tb = (mode == ctsu_pkg::MODE_OFF) ? ctsu_pkg::CTSU_TB_NONE :
                  is_pwm ? ctsu_pkg::CTSU_TB_SECOND :
                  sel_third_v[u] ? ctsu_pkg::CTSU_TB_THIRD :
                  ctsu_pkg::CTSU_TB_FIRST;
      assign tmr_val = (tb == ctsu_pkg::CTSU_TB_THIRD) ? timers_in.third :
                       timers_in.first;

      // A capture wins over a software write in the same cycle, and a
      // newer capture simply replaces an unread older one.
      assign low_nxt = cap ? tmr_val[DW-1:0] :
                       wr_low ? bus_in.wdata : low_r;
      assign high_nxt = cap ? tmr_val[ctsu_pkg::TMR_W-1:DW] :
                        wr_high ? bus_in.wdata : high_r;
      // Hardware set beats a software clear in the same cycle.
      assign flag_nxt = cap | (wr_flags ? bus_in.wdata[u] : flag_r);

      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          ctrl_r <= ctsu_pkg::CTRL_RST;
          low_r <= ctsu_pkg::DATA_RST;
          high_r <= ctsu_pkg::DATA_RST;
          flag_r <= 1'h0;
        end else begin
          if (wr_ctrl) begin
            ctrl_r <= bus_in.wdata & ctsu_pkg::CTRL_IMPL_MASK;
          end
          low_r <= low_nxt;
          high_r <= high_nxt;
          flag_r <= flag_nxt;
        end
      end

      assign ctrl_v[u] = ctrl_r;
      assign low_v[u] = low_r;
      assign high_v[u] = high_r;
      assign flag_v[u] = flag_r;
      assign rd_hit_v[u] = a_ctrl | a_low | a_high;
      assign rd_data_v[u] = a_ctrl ? ctrl_r : a_low ? low_r : high_r;
      assign time_base_out[u] = tb;
      assign special_v[u] = (mode == ctsu_pkg::MODE_CMP_SPECIAL) && cmp_match_in[u];
      assign hit_first_v[u] = special_v[u] && (tb == ctsu_pkg::CTSU_TB_FIRST);
      assign hit_third_v[u] = special_v[u] && (tb == ctsu_pkg::CTSU_TB_THIRD);
    end
  endgenerate

  // Special event trigger: reset the shared timer; a capturing unit on
  // the same timer then samples the restarted count.
  wire first_rst_nxt = |hit_first_v;
  wire third_rst_nxt = |hit_third_v;

  // Read mux; unmapped offsets read as zero.
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < NU; i++) begin
      if (rd_hit_v[i]) begin
        rd_mux = rd_data_v[i];
      end
    end
    if (bus_in.addr == ctsu_pkg::OFS_T3CTL) begin
      rd_mux = t3ctl_r;
    end else if (bus_in.addr == ctsu_pkg::OFS_FLAGS) begin
      rd_mux = DW'(flag_v);
    end else if (bus_in.addr == ctsu_pkg::OFS_IEN) begin
      rd_mux = DW'(ien_r);
    end else if (bus_in.addr == ctsu_pkg::OFS_ROUTE) begin
      rd_mux = DW'(route_r);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      t3ctl_r <= ctsu_pkg::T3CTL_RST;
      ien_r <= '0;
      route_r <= ctsu_pkg::ROUTE_RST;
      rdata_r <= '0;
      first_rst_r <= 1'h0;
      third_rst_r <= 1'h0;
    end else begin
      if (wr_t3ctl) begin
        t3ctl_r <= bus_in.wdata;
      end
      if (wr_ien) begin
        ien_r <= bus_in.wdata[NU-1:0];
      end
      if (wr_route) begin
        route_r <= bus_in.wdata[0];
      end
      rdata_r <= bus_in.rd ? rd_mux : '0;
      first_rst_r <= first_rst_nxt;
      third_rst_r <= third_rst_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign first_timer_reset_out = first_rst_r;
  assign third_timer_reset_out = third_rst_r;
  assign unit_irq_flag_out = flag_v;
  assign unit_irq_enable_out = ien_r;
  assign second_unit_pin_route_cfg_out = route_r;

endmodule : ctsu_top

// File: rtl/ctsu_pkg.sv
// Purpose: Constants and types for the capture timer share unit.
// Assumes: One 100 MHz system clock, synchronous active-low reset.
// Notes: Register offsets are word indices on an 8-bit register port.
//
// Function
// - Control, low and high data registers read/write.
// - Capture/compare use first/third timer, PWM second.
// - Timer choice from third timer control bits.
// - Both units run together, may share timers.
// - Capture units pick first/third timer independently.
// - Special trigger reset hits same-timer capturing unit.
// - Both PWM units share second timer.
// - Capture copies full 16-bit timer into pair.
// - Events: falling, rising, 4th rising, 16th rising.
// - Capture sets flag until software clears it.
// - New capture overwrites unread stored value.
// - Prescaler cleared when off, not capturing, reset.
// - Prescaler switch keeps count, may flag early.
// - Second unit pin: route bit 1 default.
// - Output-driven pin level still makes captures.
// - Mode codes 0100 to 0111 select capture.
// - Mode 0000 disables unit, clears prescaler.
package ctsu_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int TMR_W = 16;
  localparam int NUM_UNITS = 2;
  localparam int MODE_W = 4;
  localparam int PRESC_W = 4;

  // Register map, per unit base plus field offset.
  localparam logic [ADDR_W-1:0] UNIT_STRIDE = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_LOW = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_T3CTL = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IEN = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_ROUTE = 4'h9;

  // Control register: bits 7-6 unimplemented, 5-4 duty bits, 3-0 mode.
  localparam logic [DATA_W-1:0] CTRL_IMPL_MASK = 8'h3f;
  localparam int T3_SEL_U0_BIT = 3;
  localparam int T3_SEL_U1_BIT = 6;

  // Reset values.
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [DATA_W-1:0] T3CTL_RST = 8'h00;
  localparam logic ROUTE_RST = 1'h1;

  // Mode codes.
  localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
  localparam logic [MODE_W-1:0] MODE_CAP_FALL = 4'h4;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_CMP_SPECIAL = 4'hb;
  localparam logic [1:0] CLASS_CAPTURE = 2'h1;
  localparam logic [1:0] CLASS_PWM = 2'h3;

  // Prescaler terminal counts.
  localparam logic [PRESC_W-1:0] PRESC_LAST4 = 4'h3;
  localparam logic [PRESC_W-1:0] PRESC_LAST16 = 4'hf;

  typedef enum logic [1:0] {
    CTSU_TB_NONE = 2'h0,
    CTSU_TB_FIRST = 2'h1,
    CTSU_TB_SECOND = 2'h2,
    CTSU_TB_THIRD = 2'h3
  } ctsu_tb_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ctsu_bus_req_t;

  typedef struct packed {
    logic [TMR_W-1:0] first;
    logic [TMR_W-1:0] second;
    logic [TMR_W-1:0] third;
  } ctsu_timers_t;

endpackage : ctsu_pkg

// File: rtl/ctsu_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels relative to the system clock.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/10ps
module ctsu_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : ctsu_sync

// File: rtl/ctsu_cap_unit.sv
// Purpose: Edge detection and prescaler for one capture unit.
// Assumes: pin_in is already synchronised to clk_sys_in.
// Notes: cap_out is a one-cycle pulse that fires the data capture.
`timescale 1ns/10ps
module ctsu_cap_unit (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Configuration and pin
  input wire logic [ctsu_pkg::MODE_W-1:0] mode_in,
  input wire logic pin_in,
  // Event
  output logic cap_out
);

  logic pin_prev_r;
  logic [ctsu_pkg::PRESC_W-1:0] presc_r;
  logic [ctsu_pkg::PRESC_W-1:0] presc_nxt;
  logic [ctsu_pkg::PRESC_W-1:0] presc_last;
  wire rise = pin_in & ~pin_prev_r;
  wire fall = ~pin_in & pin_prev_r;
  wire cap_mode = (mode_in[3:2] == ctsu_pkg::CLASS_CAPTURE);
  wire prescaled = cap_mode && mode_in[1];
  // A count left over from a larger setting still fires on the next edge.
  wire presc_hit = rise && (presc_r >= presc_last);

  assign presc_last = (mode_in == ctsu_pkg::MODE_CAP_RISE4) ?
                      ctsu_pkg::PRESC_LAST4 : ctsu_pkg::PRESC_LAST16;

  always_comb begin
    presc_nxt = presc_r;
    if (!cap_mode) begin
      presc_nxt = '0;
    end else if (prescaled && rise) begin
      presc_nxt = presc_hit ? '0 : presc_r + 1'b1;
    end
  end

  assign cap_out = (mode_in == ctsu_pkg::MODE_CAP_FALL && fall) ||
                   (mode_in == ctsu_pkg::MODE_CAP_RISE && rise) ||
                   (prescaled && presc_hit);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pin_prev_r <= 1'h0;
      presc_r <= '0;
    end else begin
      pin_prev_r <= pin_in;
      presc_r <= presc_nxt;
    end
  end

endmodule : ctsu_cap_unit

// File: sim/ctsu_props.sv
// Purpose: Port-level properties of the capture timer share unit.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Pin-to-flag latency is allowed one cycle of slack.
`timescale 1ns/10ps
module ctsu_props (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Register port
  input wire ctsu_pkg::ctsu_bus_req_t bus_in,
  input wire logic [ctsu_pkg::DATA_W-1:0] rdata_out,
  // Timers
  input wire ctsu_pkg::ctsu_timers_t timers_in,
  input wire logic [ctsu_pkg::NUM_UNITS-1:0] cmp_match_in,
  input wire logic first_timer_reset_out,
  input wire logic third_timer_reset_out,
  input wire ctsu_pkg::ctsu_tb_t [ctsu_pkg::NUM_UNITS-1:0] time_base_out,
  // Pins
  input wire logic first_unit_pin_in,
  input wire logic default_route_pin_in,
  input wire logic alternate_route_pin_in,
  // Status
  input wire logic [ctsu_pkg::NUM_UNITS-1:0] unit_irq_flag_out,
  input wire logic [ctsu_pkg::NUM_UNITS-1:0] unit_irq_enable_out,
  input wire logic second_unit_pin_route_cfg_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  localparam ctsu_pkg::ctsu_tb_t T1 = ctsu_pkg::CTSU_TB_FIRST;
  localparam ctsu_pkg::ctsu_tb_t T3 = ctsu_pkg::CTSU_TB_THIRD;
  wire wr_f = bus_in.wr && bus_in.addr == ctsu_pkg::OFS_FLAGS;
  wire wr_r = bus_in.wr && bus_in.addr == ctsu_pkg::OFS_ROUTE;
  wire rd_f = bus_in.rd && bus_in.addr == ctsu_pkg::OFS_FLAGS;
  wire p0 = first_unit_pin_in;
  rdata_idle_a: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
    else $error("read data not zero when idle");
  unmapped_read_a: assert property (bus_in.rd && bus_in.addr > ctsu_pkg::OFS_ROUTE |=>
    rdata_out == 8'h00) else $error("unmapped read not zero");
  flag_read_a: assert property (rd_f |=> rdata_out == {6'h00, $past(unit_irq_flag_out)})
    else $error("flag read mismatch");
  flag_hold_a: assert property ($past(rstn_in) &&
    |($past(unit_irq_flag_out) & ~unit_irq_flag_out) |-> $past(wr_f)) else $error("flag lost");
  flag_cause_a: assert property ($rose(unit_irq_flag_out[0]) && !$past(wr_f) |->
    $past(p0, 3) != $past(p0, 4) || $past(p0, 4) != $past(p0, 5)) else $error("flag no edge");
  rst_third_a: assert property (third_timer_reset_out |-> $past(cmp_match_in[0] &&
    time_base_out[0] == T3 || cmp_match_in[1] && time_base_out[1] == T3)) else $error("rst3");
  rst_first_a: assert property (first_timer_reset_out |-> $past(cmp_match_in[0] &&
    time_base_out[0] == T1 || cmp_match_in[1] && time_base_out[1] == T1)) else $error("rst1");
  base_hold_a: assert property ($past(rstn_in) && !$past(bus_in.wr) |->
    $stable(time_base_out)) else $error("time base moved");
  route_hold_a: assert property ($past(rstn_in) && !$past(wr_r) |->
    $stable(second_unit_pin_route_cfg_out)) else $error("route moved");
  cover property ($rose(unit_irq_flag_out[0]));
  cover property ($rose(unit_irq_flag_out[1]));
  cover property (third_timer_reset_out);
endmodule : ctsu_props

bind ctsu_top ctsu_props u_props (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .timers_in(timers_in),
  .cmp_match_in(cmp_match_in), .first_timer_reset_out(first_timer_reset_out),
  .third_timer_reset_out(third_timer_reset_out), .time_base_out(time_base_out),
  .first_unit_pin_in(first_unit_pin_in), .default_route_pin_in(default_route_pin_in),
  .alternate_route_pin_in(alternate_route_pin_in), .unit_irq_flag_out(unit_irq_flag_out),
  .unit_irq_enable_out(unit_irq_enable_out),
  .second_unit_pin_route_cfg_out(second_unit_pin_route_cfg_out));

// File: sim/ctsu_pin_drv.sv
// Purpose: External source for the three capture pins.
// Assumes: Levels change just after a rising clock edge.
// Notes: Each level lasts at least five cycles, above the two-cycle minimum.
`timescale 1ns/10ps
module ctsu_pin_drv (
  // Clock
  input wire logic clk_sys_in,
  // Pins
  output logic [2:0] pins_out
);
  initial pins_out = 3'h0;
  // Pins are always driven, as by an input or an output latch.
  task automatic level(input int idx, input logic v);
    @(posedge clk_sys_in);
    pins_out[idx] <= v;
    repeat (4) @(posedge clk_sys_in);
  endtask : level
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      level(idx, 1'b1);
      level(idx, 1'b0);
    end
  endtask : pulse
endmodule : ctsu_pin_drv

// File: sim/test_capture_timer_share_unit.sv
// Purpose: Self-checking bench for the capture timer share unit.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes: Timers are held still around each capture.
`timescale 1ns/10ps
module test_capture_timer_share_unit;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  ctsu_pkg::ctsu_bus_req_t bus = '0;
  ctsu_pkg::ctsu_timers_t timers = '0;
  logic [1:0] cmp = 2'h0;
  logic [7:0] rdata;
  logic [2:0] pins;
  logic rst1, rst3, route;
  logic [1:0] flags, ien;
  ctsu_pkg::ctsu_tb_t [1:0] tbase;
  int n_fail = 0;
  int checks = 0;
  int n;
  logic [15:0] e;
  always #5 clk_sys_in = ~clk_sys_in;
  ctsu_top u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus_in(bus),
    .rdata_out(rdata), .timers_in(timers), .cmp_match_in(cmp),
    .first_timer_reset_out(rst1), .third_timer_reset_out(rst3), .time_base_out(tbase),
    .first_unit_pin_in(pins[0]), .default_route_pin_in(pins[1]),
    .alternate_route_pin_in(pins[2]), .unit_irq_flag_out(flags),
    .unit_irq_enable_out(ien), .second_unit_pin_route_cfg_out(route));
  ctsu_pin_drv u_pins (.clk_sys_in(clk_sys_in), .pins_out(pins));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    bus.rd <= 1'b0;
    #1 chk("rdata", {8'h00, rdata}, {8'h00, x});
  endtask : rc
  task automatic trig(input logic [1:0] m, input logic [15:0] x);
    @(posedge clk_sys_in) cmp <= m;
    @(posedge clk_sys_in) cmp <= 2'h0;
    #1 chk("timer_reset", {14'h0, rst3, rst1}, x);
  endtask : trig
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 10; a++) begin
      rc(4'(a), (a == 9) ? 8'h01 : 8'h00);
    end
    rc(4'hf, 8'h00);
    wr(4'h6, 8'h08);
    wr(4'h0, 8'h05);
    wr(4'h3, 8'h05);
    #1 chk("bases", {12'h0, tbase}, {12'h0, 4'h7});
    wr(4'h0, 8'h0c);
    wr(4'h3, 8'h0d);
    #1 chk("bases", {12'h0, tbase}, {12'h0, 4'ha});
    wr(4'h3, 8'h00);
    #1 chk("bases", {12'h0, tbase}, {12'h0, 4'h2});
    for (int a = 0; a < 7; a++) begin
      wr(4'(a), 8'hc5 ^ 8'(a));
      rc(4'(a), (a % 3 == 0 && a < 6) ? (8'hc5 ^ 8'(a)) & 8'h3f : 8'hc5 ^ 8'(a));
    end
    wr(4'h8, 8'h03);
    #1 chk("irq_enable", {14'h0, ien}, 16'h0003);
    for (int m = 4; m < 8; m++) begin
      n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      wr(4'h0, 8'h00);
      wr(4'h6, (m == 7) ? 8'h08 : 8'h00);
      wr(4'h0, 8'(m));
      wr(4'h7, 8'h00);
      u_pins.pulse(0, n - 1);
      if (m == 4) u_pins.level(0, 1'b1);
      rc(4'h7, 8'h00);
      e = (m == 7) ? 16'h3400 + 16'(m) : 16'h1200 + 16'(m);
      @(posedge clk_sys_in) timers <= '{16'h1200 + 16'(m), 16'h5555, 16'h3400 + 16'(m)};
      if (m == 4) u_pins.level(0, 1'b0);
      else u_pins.pulse(0, 1);
      rc(4'h7, 8'h01);
      rc(4'h1, e[7:0]);
      rc(4'h2, e[15:8]);
    end
    wr(4'h0, 8'h06);
    wr(4'h7, 8'h00);
    u_pins.pulse(0, 2);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h06);
    u_pins.pulse(0, 3);
    rc(4'h7, 8'h00);
    u_pins.pulse(0, 1);
    rc(4'h7, 8'h01);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h07);
    wr(4'h7, 8'h00);
    u_pins.pulse(0, 5);
    wr(4'h0, 8'h06);
    u_pins.pulse(0, 1);
    rc(4'h7, 8'h01);
    wr(4'h3, 8'h05);
    wr(4'h7, 8'h00);
    u_pins.pulse(2, 1);
    rc(4'h7, 8'h00);
    u_pins.pulse(1, 1);
    rc(4'h7, 8'h02);
    wr(4'h9, 8'h00);
    wr(4'h7, 8'h00);
    rc(4'h9, 8'h00);
    chk("route", {15'h0, route}, 16'h0000);
    u_pins.pulse(1, 1);
    rc(4'h7, 8'h00);
    @(posedge clk_sys_in) timers.first <= 16'h0a0b;
    u_pins.pulse(2, 1);
    @(posedge clk_sys_in) timers.first <= 16'h0c0d;
    u_pins.pulse(2, 1);
    rc(4'h7, 8'h02);
    rc(4'h4, 8'h0d);
    rc(4'h5, 8'h0c);
    chk("flags", {14'h0, flags}, 16'h0002);
    wr(4'h6, 8'h48);
    wr(4'h0, 8'h05);
    wr(4'h3, 8'h0b);
    trig(2'h3, 16'h0002);
    wr(4'h6, 8'h40);
    wr(4'h0, 8'h0b);
    trig(2'h1, 16'h0001);
    // The write lands on the very edge at which the rising pin is captured.
    wr(4'h0, 8'h05);
    @(posedge clk_sys_in) timers.first <= 16'h5aa5;
    fork
      u_pins.level(0, 1'b1);
      begin
        repeat (2) @(posedge clk_sys_in);
        wr(4'h1, 8'h99);
      end
    join
    rc(4'h1, 8'ha5);
    u_pins.level(0, 1'b0);
    // A flag clear meets a capture: the set must win for unit 0 only.
    fork
      u_pins.level(0, 1'b1);
      begin
        repeat (2) @(posedge clk_sys_in);
        wr(4'h7, 8'h00);
      end
    join
    rc(4'h7, 8'h01);
    u_pins.level(0, 1'b0);
    // A reset in mid-count must leave the prescaler empty.
    wr(4'h0, 8'h06);
    u_pins.pulse(0, 2);
    @(posedge clk_sys_in) rstn_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    #1 chk("reset_state", {flags, ien, route, rst3, rst1, tbase}, 16'h0040);
    wr(4'h0, 8'h06);
    u_pins.pulse(0, 3);
    rc(4'h7, 8'h00);
    u_pins.pulse(0, 1);
    rc(4'h7, 8'h01);
    stop_test();
  end
endmodule : test_capture_timer_share_unit
